// ===== rtl/lvtc_cfg.svh
// Constants for the LCD drive-voltage temperature compensation block.
`ifndef LVTC_CFG_SVH
`define LVTC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the APB port)
// ----------------------------------------------------------------------
`define LVTC_ADDR_CTRL 12'h000
`define LVTC_ADDR_LIM1 12'h004
`define LVTC_ADDR_LIM2 12'h008
`define LVTC_ADDR_LIM3 12'h00C
`define LVTC_ADDR_LIM4 12'h010
`define LVTC_ADDR_SLOPE 12'h014
`define LVTC_ADDR_VSET 12'h018
`define LVTC_ADDR_TEMP 12'h01C
`define LVTC_ADDR_STATUS 12'h020
`define LVTC_ADDR_EFF 12'h024

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LVTC_CTRL_EN_BIT 0
`define LVTC_SLOPE_FIELD_W 3
`define LVTC_STAT_OFS_LSB 0
`define LVTC_STAT_REGION_LSB 16
`define LVTC_STAT_ACTIVE_BIT 24
`define LVTC_STAT_NOTEMP_BIT 25
`define LVTC_STAT_ORDER_BIT 26

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LVTC_RST_EN 1'h0
`define LVTC_RST_LIM_A 3'h0
`define LVTC_RST_LIM_B 3'h7
`define LVTC_RST_SLOPE 18'h0_0000
`define LVTC_RST_VSET 9'h000
`define LVTC_RST_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// Temperature code landmarks and limit decoding
// ----------------------------------------------------------------------
`define LVTC_TEMP_REF 8'h60
`define LVTC_TEMP_TOP 8'hE7
`define LVTC_TEMP_NONE 8'hFF
`define LVTC_COLD_BASE 8'h0A
`define LVTC_COLD_STEP 8'h0A
`define LVTC_WARM_BASE 8'h6E
`define LVTC_WARM_STEP 8'h0E

// ----------------------------------------------------------------------
// Slope coefficients in eighths of a setting step per code step
// ----------------------------------------------------------------------
`define LVTC_COEF_0 6'sh00
`define LVTC_COEF_1 6'sh3F
`define LVTC_COEF_2 6'sh3E
`define LVTC_COEF_3 6'sh3C
`define LVTC_COEF_4 6'sh36
`define LVTC_COEF_5 6'sh01
`define LVTC_COEF_6 6'sh02
`define LVTC_COEF_7 6'sh04

// ----------------------------------------------------------------------
// Rounding and saturation
// ----------------------------------------------------------------------
`define LVTC_FRAC_BITS 3
`define LVTC_ROUND_HALF 14'sh0004
`define LVTC_OFS_MAX 11'sh0FF
`define LVTC_OFS_MIN 11'sh700
`define LVTC_VCODE_MAX 11'sh1FF
`define LVTC_VCODE_MIN 11'sh000

`endif

// ===== rtl/lvtc_pkg.sv
// Types shared by the temperature compensation design files.
package lvtc_pkg;

    // ------------------------------------------------------------------
    // Which stretch of the temperature range produced the correction
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LVTC_REG_OFF,
        LVTC_REG_COLD1,
        LVTC_REG_COLD2,
        LVTC_REG_COLD3,
        LVTC_REG_WARM4,
        LVTC_REG_WARM5,
        LVTC_REG_WARM6
    } lvtc_region_t;

    typedef logic [7:0] lvtc_tcode_t;
    typedef logic [2:0] lvtc_sel_t;
    typedef logic signed [13:0] lvtc_prod_t;

endpackage

// ===== rtl/lvtc_slope_mul.sv
// One temperature segment: its length times its selected slope.
`timescale 1ns/1ns
`include "lvtc_cfg.svh"

module lvtc_slope_mul (
    // Segment length in temperature-code steps
    input wire lvtc_pkg::lvtc_tcode_t seg_len,
    // Slope selection code
    input wire lvtc_pkg::lvtc_sel_t slope_code,
    // Product in eighths of a setting step
    output lvtc_pkg::lvtc_prod_t prod
);

    // ------------------------------------------------------------------
    // Coefficient lookup
    // ------------------------------------------------------------------
    // Coefficients are kept in eighths so that every entry is exact.
    function automatic logic signed [5:0] slope_coef(input lvtc_pkg::lvtc_sel_t code);
        case (code)
            3'h0: slope_coef = `LVTC_COEF_0;
            3'h1: slope_coef = `LVTC_COEF_1;
            3'h2: slope_coef = `LVTC_COEF_2;
            3'h3: slope_coef = `LVTC_COEF_3;
            3'h4: slope_coef = `LVTC_COEF_4;
            3'h5: slope_coef = `LVTC_COEF_5;
            3'h6: slope_coef = `LVTC_COEF_6;
            default: slope_coef = `LVTC_COEF_7;
        endcase
    endfunction

    logic signed [8:0] len_s;
    logic signed [14:0] full;

    // ------------------------------------------------------------------
    // Multiply
    // ------------------------------------------------------------------
    always_comb begin
        len_s = $signed({1'b0, seg_len});
        full = len_s * slope_coef(slope_code);
        prod = full[13:0];
    end

endmodule

// ===== rtl/lvtc_top.sv
// LCD drive-voltage temperature compensation with an APB register port.
// Function
// RULE1 - Correction applied only when enable set
// RULE2 - Six temperature regions, each own slope
// RULE3 - Host programs four limits, one command each
// RULE4 - Limit codes decode to 10+10n, 110+14n
// RULE5 - Misordered limits suppress compensation entirely
// RULE6 - Eight slopes, chosen per region independently
// RULE7 - Slope code maps to fixed coefficient table
// RULE8 - Coefficient is slope times step over LSB
// RULE9 - Cold side near reference uses slopes three, two
// RULE10 - Coldest region adds slope one segment
// RULE11 - Warm side accumulates slopes four to six
// RULE12 - Correction is nine-bit, zero at reference
// RULE13 - Effective code is setting plus correction
// RULE14 - Code FFh means no valid reading
// RULE15 - Reference temperature sits at code 96
// RULE16 - Correction forced zero when inactive
// RULE17 - Round to nearest, saturate to nine bits
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "lvtc_cfg.svh"

module lvtc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Temperature code from the sensor filter, same clock
    input wire lvtc_pkg::lvtc_tcode_t temp_code,
    // Compensation results
    output logic [8:0] comp_offset,
    output logic [8:0] vlcd_code
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic lvtc_pkg::lvtc_tcode_t cold_limit(input lvtc_pkg::lvtc_sel_t code);
        cold_limit = `LVTC_COLD_BASE + 8'(code) * `LVTC_COLD_STEP; // RULE4
    endfunction

    function automatic lvtc_pkg::lvtc_tcode_t warm_limit(input lvtc_pkg::lvtc_sel_t code);
        warm_limit = `LVTC_WARM_BASE + 8'(code) * `LVTC_WARM_STEP; // RULE4
    endfunction

    function automatic lvtc_pkg::lvtc_tcode_t usub(input lvtc_pkg::lvtc_tcode_t a,
                                                   input lvtc_pkg::lvtc_tcode_t b);
        usub = (a > b) ? a - b : 8'h00;
    endfunction

    function automatic lvtc_pkg::lvtc_tcode_t umax(input lvtc_pkg::lvtc_tcode_t a,
                                                   input lvtc_pkg::lvtc_tcode_t b);
        umax = (a > b) ? a : b;
    endfunction

    function automatic lvtc_pkg::lvtc_tcode_t umin(input lvtc_pkg::lvtc_tcode_t a,
                                                   input lvtc_pkg::lvtc_tcode_t b);
        umin = (a < b) ? a : b;
    endfunction

    // Applies the APB byte strobes to the low bits of a register.
    function automatic logic [31:0] merge(input logic [31:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic comp_enable;
    lvtc_pkg::lvtc_sel_t cold_limit_a_code;
    lvtc_pkg::lvtc_sel_t cold_limit_b_code;
    lvtc_pkg::lvtc_sel_t warm_limit_a_code;
    lvtc_pkg::lvtc_sel_t warm_limit_b_code;
    logic [17:0] slope_codes;
    logic [8:0] vset;
    logic next_comp_enable;
    lvtc_pkg::lvtc_sel_t next_cold_limit_a_code;
    lvtc_pkg::lvtc_sel_t next_cold_limit_b_code;
    lvtc_pkg::lvtc_sel_t next_warm_limit_a_code;
    lvtc_pkg::lvtc_sel_t next_warm_limit_b_code;
    logic [17:0] next_slope_codes;
    logic [8:0] next_vset;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Compute-side state.
    lvtc_pkg::lvtc_region_t region;
    lvtc_pkg::lvtc_region_t next_region;
    logic comp_active;
    logic next_comp_active;
    logic [8:0] next_comp_offset;
    logic [8:0] next_vlcd_code;

    // Status view shared by the read decode.
    logic temp_none;
    logic order_err;
    logic [31:0] status_word;

    // ------------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------------
    // The slave answers in the first access cycle: pready is raised by the
    // setup cycle, so every transfer takes exactly two cycles.
    always_comb begin
        logic wr_en;
        logic [31:0] wmask;
        wr_en = 1'b0;
        wmask = `LVTC_RST_WORD;
        next_comp_enable = comp_enable;
        next_cold_limit_a_code = cold_limit_a_code;
        next_cold_limit_b_code = cold_limit_b_code;
        next_warm_limit_a_code = warm_limit_a_code;
        next_warm_limit_b_code = warm_limit_b_code;
        next_slope_codes = slope_codes;
        next_vset = vset;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = psel && !penable;
        wr_en = psel && penable && pready && pwrite && !pslverr;
        if (psel && !penable) begin
            next_prdata = `LVTC_RST_WORD;
            case (paddr)
                `LVTC_ADDR_CTRL: begin
                    next_prdata[`LVTC_CTRL_EN_BIT] = comp_enable;
                end
                `LVTC_ADDR_LIM1: begin
                    next_prdata[2:0] = cold_limit_a_code;
                end
                `LVTC_ADDR_LIM2: begin
                    next_prdata[2:0] = cold_limit_b_code;
                end
                `LVTC_ADDR_LIM3: begin
                    next_prdata[2:0] = warm_limit_a_code;
                end
                `LVTC_ADDR_LIM4: begin
                    next_prdata[2:0] = warm_limit_b_code;
                end
                `LVTC_ADDR_SLOPE: begin
                    next_prdata[17:0] = slope_codes;
                end
                `LVTC_ADDR_VSET: begin
                    next_prdata[8:0] = vset;
                end
                `LVTC_ADDR_TEMP: begin
                    next_prdata[7:0] = temp_code;
                end
                `LVTC_ADDR_STATUS: begin
                    next_prdata = status_word;
                end
                `LVTC_ADDR_EFF: begin
                    next_prdata[8:0] = vlcd_code;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (wr_en) begin
            case (paddr)
                `LVTC_ADDR_CTRL: begin
                    wmask = merge({31'h0, comp_enable}, pwdata, pstrb);
                    next_comp_enable = wmask[`LVTC_CTRL_EN_BIT]; // RULE1
                end
                `LVTC_ADDR_LIM1: begin
                    wmask = merge({29'h0, cold_limit_a_code}, pwdata, pstrb);
                    next_cold_limit_a_code = wmask[2:0]; // RULE3
                end
                `LVTC_ADDR_LIM2: begin
                    wmask = merge({29'h0, cold_limit_b_code}, pwdata, pstrb);
                    next_cold_limit_b_code = wmask[2:0]; // RULE3
                end
                `LVTC_ADDR_LIM3: begin
                    wmask = merge({29'h0, warm_limit_a_code}, pwdata, pstrb);
                    next_warm_limit_a_code = wmask[2:0]; // RULE3
                end
                `LVTC_ADDR_LIM4: begin
                    wmask = merge({29'h0, warm_limit_b_code}, pwdata, pstrb);
                    next_warm_limit_b_code = wmask[2:0]; // RULE3
                end
                `LVTC_ADDR_SLOPE: begin
                    wmask = merge({14'h0, slope_codes}, pwdata, pstrb);
                    next_slope_codes = wmask[17:0]; // RULE6
                end
                `LVTC_ADDR_VSET: begin
                    wmask = merge({23'h0, vset}, pwdata, pstrb);
                    next_vset = wmask[8:0];
                end
                default: begin
                    wmask = `LVTC_RST_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            comp_enable <= `LVTC_RST_EN;
            cold_limit_a_code <= `LVTC_RST_LIM_A;
            cold_limit_b_code <= `LVTC_RST_LIM_B;
            warm_limit_a_code <= `LVTC_RST_LIM_A;
            warm_limit_b_code <= `LVTC_RST_LIM_B;
            slope_codes <= `LVTC_RST_SLOPE;
            vset <= `LVTC_RST_VSET;
            prdata <= `LVTC_RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            comp_enable <= next_comp_enable;
            cold_limit_a_code <= next_cold_limit_a_code;
            cold_limit_b_code <= next_cold_limit_b_code;
            warm_limit_a_code <= next_warm_limit_a_code;
            warm_limit_b_code <= next_warm_limit_b_code;
            slope_codes <= next_slope_codes;
            vset <= next_vset;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Segment lengths
    // ------------------------------------------------------------------
    lvtc_pkg::lvtc_tcode_t cold_limit_a;
    lvtc_pkg::lvtc_tcode_t cold_limit_b;
    lvtc_pkg::lvtc_tcode_t warm_limit_a;
    lvtc_pkg::lvtc_tcode_t warm_limit_b;
    lvtc_pkg::lvtc_tcode_t seg_len [6];
    lvtc_pkg::lvtc_prod_t seg_prod [6];

    assign cold_limit_a = cold_limit(cold_limit_a_code);
    assign cold_limit_b = cold_limit(cold_limit_b_code);
    assign warm_limit_a = warm_limit(warm_limit_a_code);
    assign warm_limit_b = warm_limit(warm_limit_b_code);
    assign temp_none = (temp_code == `LVTC_TEMP_NONE); // RULE14
    assign order_err = (cold_limit_a_code >= cold_limit_b_code) ||
                       (warm_limit_a_code >= warm_limit_b_code); // RULE5

    // Each length is the part of its segment lying between the code and the
    // reference, so the sum telescopes to the piecewise-linear curve.
    assign seg_len[0] = usub(cold_limit_a, temp_code); // RULE10
    assign seg_len[1] = usub(cold_limit_b, umax(temp_code, cold_limit_a)); // RULE9 RULE10
    assign seg_len[2] = usub(`LVTC_TEMP_REF, umax(temp_code, cold_limit_b)); // RULE9 RULE15
    assign seg_len[3] = usub(umin(temp_code, warm_limit_a), `LVTC_TEMP_REF); // RULE11
    assign seg_len[4] = usub(umin(temp_code, warm_limit_b), warm_limit_a); // RULE11
    // Codes above the top of the table hold the value reached at the top.
    assign seg_len[5] = usub(umin(temp_code, `LVTC_TEMP_TOP), warm_limit_b); // RULE11

    for (genvar g = 0; g < 6; g++) begin : gen_seg
        lvtc_slope_mul u_mul (
            .seg_len(seg_len[g]),
            .slope_code(slope_codes[g*`LVTC_SLOPE_FIELD_W +: `LVTC_SLOPE_FIELD_W]), // RULE2
            .prod(seg_prod[g]) // RULE7 RULE8
        );
    end

    // ------------------------------------------------------------------
    // Correction and effective code
    // ------------------------------------------------------------------
    always_comb begin
        logic signed [13:0] sum8;
        logic signed [10:0] rounded;
        logic signed [10:0] ofs;
        logic signed [10:0] eff;
        ofs = 11'sh000;
        sum8 = seg_prod[3] + seg_prod[4] + seg_prod[5]
             - seg_prod[0] - seg_prod[1] - seg_prod[2]; // RULE9 RULE10 RULE11
        next_comp_active = comp_enable && !temp_none && !order_err; // RULE1 RULE5 RULE14
        sum8 = sum8 + `LVTC_ROUND_HALF; // RULE17
        rounded = 11'(sum8 >>> `LVTC_FRAC_BITS);
        if (!next_comp_active) begin
            ofs = 11'sh000; // RULE16
        end else if (rounded > `LVTC_OFS_MAX) begin
            ofs = `LVTC_OFS_MAX; // RULE17
        end else if (rounded < `LVTC_OFS_MIN) begin
            ofs = `LVTC_OFS_MIN; // RULE17
        end else begin
            ofs = rounded;
        end
        next_comp_offset = ofs[8:0]; // RULE12
        // The setting in flight uses the registered correction, one cycle old.
        eff = $signed({2'b00, vset}) + $signed({{2{comp_offset[8]}}, comp_offset}); // RULE13
        if (eff > `LVTC_VCODE_MAX) begin
            eff = `LVTC_VCODE_MAX;
        end else if (eff < `LVTC_VCODE_MIN) begin
            eff = `LVTC_VCODE_MIN;
        end
        next_vlcd_code = eff[8:0];
        if (!next_comp_active) begin
            next_region = lvtc_pkg::LVTC_REG_OFF;
        end else if (temp_code <= cold_limit_a) begin
            next_region = lvtc_pkg::LVTC_REG_COLD1;
        end else if (temp_code <= cold_limit_b) begin
            next_region = lvtc_pkg::LVTC_REG_COLD2;
        end else if (temp_code <= `LVTC_TEMP_REF) begin
            next_region = lvtc_pkg::LVTC_REG_COLD3;
        end else if (temp_code <= warm_limit_a) begin
            next_region = lvtc_pkg::LVTC_REG_WARM4;
        end else if (temp_code <= warm_limit_b) begin
            next_region = lvtc_pkg::LVTC_REG_WARM5;
        end else begin
            next_region = lvtc_pkg::LVTC_REG_WARM6;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            comp_offset <= 9'h000;
            vlcd_code <= `LVTC_RST_VSET;
            region <= lvtc_pkg::LVTC_REG_OFF;
            comp_active <= 1'b0;
        end else begin
            comp_offset <= next_comp_offset;
            vlcd_code <= next_vlcd_code;
            region <= next_region;
            comp_active <= next_comp_active;
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_comb begin
        status_word = `LVTC_RST_WORD;
        status_word[`LVTC_STAT_OFS_LSB +: 9] = comp_offset;
        status_word[`LVTC_STAT_REGION_LSB +: 3] = region;
        status_word[`LVTC_STAT_ACTIVE_BIT] = comp_active;
        status_word[`LVTC_STAT_NOTEMP_BIT] = temp_none;
        status_word[`LVTC_STAT_ORDER_BIT] = order_err;
    end

endmodule

// ===== sim/lvtc_top_assertions.sv
// Concurrent checks on the ports of the compensation block.
`timescale 1ns/1ns
module lvtc_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Compensation
    input wire lvtc_pkg::lvtc_tcode_t temp_code,
    input wire logic [8:0] comp_offset,
    input wire logic [8:0] vlcd_code
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Shadow of the enable bit, so a disabled block can be judged from the ports alone.
    logic en_q;
    logic next_en;
    always_comb begin
        next_en = en_q;
        if (psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0]) begin
            next_en = pwdata[0];
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= next_en;
        end
    end
    setup_answer_a: assert property ((psel && !penable) |=> pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_decode_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 12'h024))
        else $error("error flag disagrees with address");
    err_data_a: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    disabled_zero_a: assert property (!en_q |=> comp_offset == 9'h000)
        else $error("correction while disabled");
    no_reading_a: assert property (temp_code == 8'hFF |=> comp_offset == 9'h000)
        else $error("correction without reading");
    ref_zero_a: assert property (temp_code == 8'h60 |=> comp_offset == 9'h000)
        else $error("correction at reference");
endmodule
bind lvtc_top lvtc_checker i_lvtc_checker (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .temp_code, .comp_offset, .vlcd_code);

// ===== sim/lvtc_host_model.sv
// Host model that issues configuration transfers on APB.
`timescale 1ns/1ns
module lvtc_host_model (
    // Clock
    input wire logic clk_sys,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // One transfer per setting; each limit goes in its own command, and all six slopes share one.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Address and data are inverted on release so a stale value is never mistaken for a live one.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ===== sim/lvtc_tb_top.sv
// Self-checking testbench for the compensation block.
`timescale 1ns/1ns
module lvtc_tb_top;
    logic clk_sys;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    lvtc_pkg::lvtc_tcode_t temp_code = 8'hFF;
    logic [8:0] comp_offset, vlcd_code;
    int n_errors = 0;
    int num_checks = 0;
    lvtc_top i_lvtc_top (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .temp_code, .comp_offset, .vlcd_code);
    lvtc_host_model i_lvtc_host_model (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t %s: got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_lvtc_host_model.xfer(1'b1, a, d, 4'hF, rd, err);
    endtask
    // Expected correction in eighths of a step, rounded half up, then saturated.
    function automatic logic [8:0] exp_ofs(int t, int en, int l1, int l2, int l3, int l4,
        logic [17:0] sl);
        int c[8] = '{0, -1, -2, -4, -10, 1, 2, 4};
        int k[6];
        int a, b, p, q, s, r;
        for (int i = 0; i < 6; i++) k[i] = c[sl[3*i +: 3]];
        a = 10 + 10 * l1;
        b = 10 + 10 * l2;
        p = 110 + 14 * l3;
        q = 110 + 14 * l4;
        if (en == 0 || t == 255 || l1 >= l2 || l3 >= l4) return 9'h000;
        if (t > 231) t = 231;
        if (t <= a) s = -(96 - b) * k[2] - (b - a) * k[1] - (a - t) * k[0];
        else if (t <= b) s = -(96 - b) * k[2] - (b - t) * k[1];
        else if (t <= 96) s = -(96 - t) * k[2];
        else if (t <= p) s = (t - 96) * k[3];
        else if (t <= q) s = (p - 96) * k[3] + (t - p) * k[4];
        else s = (p - 96) * k[3] + (q - p) * k[4] + (t - q) * k[5];
        r = (s + 4) >>> 3;
        r = r > 255 ? 255 : (r < -256 ? -256 : r);
        return r[8:0];
    endfunction
    task automatic run_cfg(int en, int l1, int l2, int l3, int l4, logic [17:0] sl, int vs);
        int tl[16];
        int v;
        logic [8:0] o;
        wr(12'h000, 32'(en));
        wr(12'h004, 32'(l1));
        wr(12'h008, 32'(l2));
        wr(12'h00C, 32'(l3));
        wr(12'h010, 32'(l4));
        wr(12'h014, {14'h0000, sl});
        wr(12'h018, 32'(vs));
        tl = '{0, 1, 10+10*l1, 11+10*l1, 10+10*l2, 11+10*l2, 95, 96, 97, 110+14*l3,
               111+14*l3, 110+14*l4, 111+14*l4, 231, 240, 255};
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            temp_code <= 8'(tl[i]);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            o = exp_ofs(tl[i], en, l1, l2, l3, l4, sl);
            v = vs + $signed(o);
            v = v > 511 ? 511 : (v < 0 ? 0 : v);
            chk(32'(comp_offset), 32'(o), "correction");
            chk(32'(vlcd_code), 32'(v), "voltage code");
        end
    endtask
    task automatic t_regs;
        logic [31:0] e[7] = '{0, 0, 7, 0, 7, 0, 0};
        for (int i = 0; i < 7; i++) begin
            i_lvtc_host_model.xfer(1'b0, 12'(4 * i), 32'h0, 4'hF, rd, err);
            chk(rd, e[i], "reset value");
        end
    endtask
    task automatic t_refuse;
        i_lvtc_host_model.xfer(1'b1, 12'h028, 32'hFFFF_FFFF, 4'hF, rd, err);
        chk(32'(err), 32'h1, "unmapped write");
        i_lvtc_host_model.xfer(1'b0, 12'h002, 32'h0, 4'hF, rd, err);
        chk({rd[30:0], err}, 32'h1, "misaligned read");
        wr(12'h01C, 32'h0000_0012);
        i_lvtc_host_model.xfer(1'b0, 12'h01C, 32'h0, 4'hF, rd, err);
        chk(rd, 32'(temp_code), "read-only temperature");
        wr(12'h018, 32'h0000_0000);
        i_lvtc_host_model.xfer(1'b1, 12'h018, 32'h0000_01FF, 4'b0001, rd, err);
        i_lvtc_host_model.xfer(1'b0, 12'h018, 32'h0, 4'hF, rd, err);
        chk(rd, 32'h0000_00FF, "byte strobe");
        i_lvtc_host_model.xfer(1'b0, 12'h020, 32'h0, 4'hF, rd, err);
        chk(rd, 32'h0200_0000, "status");
    endtask
    task automatic t_regions;
        run_cfg(1, 2, 5, 1, 4, {3'd7, 3'd6, 3'd5, 3'd3, 3'd2, 3'd1}, 100);
        run_cfg(1, 0, 7, 0, 7, {3'd4, 3'd4, 3'd4, 3'd7, 3'd7, 3'd7}, 0);
        run_cfg(1, 3, 4, 6, 7, {3'd5, 3'd6, 3'd7, 3'd4, 3'd6, 3'd0}, 500);
    endtask
    task automatic t_inactive;
        run_cfg(0, 2, 5, 1, 4, {3'd7, 3'd6, 3'd5, 3'd3, 3'd2, 3'd1}, 50);
        run_cfg(1, 4, 4, 1, 4, {3'd7, 3'd6, 3'd5, 3'd3, 3'd2, 3'd1}, 50);
        run_cfg(1, 1, 2, 5, 3, {3'd7, 3'd6, 3'd5, 3'd3, 3'd2, 3'd1}, 50);
    endtask
    task automatic final_report;
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_refuse();
        t_regions();
        t_inactive();
        final_report();
    end
    // The full run needs under a thousand cycles; this bound is over twenty times that.
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
endmodule
